// ### dram_link_map.svh
// offsets, field positions, reset values and timing counts of the dram command link
// assumes inclusion by bare name from every file that needs a figure
`ifndef DRAM_LINK_MAP_SVH
`define DRAM_LINK_MAP_SVH
`define DRAM_ADDR_W 16
`define DRAM_BANK_W 3
`define DRAM_BANKS 8
`define DRAM_ROW_W 16
`define DRAM_COL_W 10
`define DRAM_MR_COUNT 4
`define DRAM_A10 10
`define DRAM_A12 12
`define MR0_BL_POS 0
`define MR0_BL_FIX8 2'h0
`define MR0_BL_OTF 2'h1
`define MR0_BL_FIX4 2'h2
`define BURST8_CK 4
`define BURST4_CK 2
`define LINK_DIV 8
`define TCKE_MIN_CK 3
`define TRFC_CK 8
`define TZQINIT_CK 512
`define TZQOPER_CK 256
`define TZQCS_CK 64
`define REG_CTRL 4'h0
`define REG_CMD 4'h4
`define REG_STATUS 4'h8
`define CTRL_RESETN_POS 0
`define CTRL_ODT_POS 1
`define CTRL_RESET 2'h0
`define CMD_CODE_POS 0
`define CMD_BANK_POS 4
`define CMD_ADDR_POS 16
`endif

// ### dram_cmd_pkg.sv
// types shared by both ends of the dram command link
// assumes nothing beyond a systemverilog compiler
package dram_cmd_pkg;
   typedef enum logic [3:0] {
      CMD_NOP, CMD_DES, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_ZQ,
      CMD_PDE, CMD_PDX, CMD_SRE, CMD_SRX
   } cmd_t;
   typedef enum logic [2:0] {S_IDLE, S_ACTIVE, S_PD_ACT, S_PD_PRE, S_SELFREF} dev_state_t;
   typedef enum logic [1:0] {C_READY, C_DRIVE, C_HOLD, C_WAIT} ctl_state_t;
endpackage : dram_cmd_pkg

// ### dram_link_if.sv
// command, address and clock-enable wires between controller and dram
// assumes the controller drives every signal
`include "dram_link_map.svh"
interface dram_link_if;
   logic ck;
   logic cke;
   logic csN;
   logic rasN;
   logic casN;
   logic weN;
   logic odt;
   logic resetN;
   logic [`DRAM_BANK_W-1:0] ba;
   logic [`DRAM_ADDR_W-1:0] a;
   modport ctrl (output ck, cke, csN, rasN, casN, weN, odt, resetN, ba, a);
   modport dev (input ck, cke, csN, rasN, casN, weN, odt, resetN, ba, a);
endinterface : dram_link_if

// ### dram_cmd_decode.sv
// pin pattern to command decode for the dram end
// assumes already synchronised strobe levels
module dram_cmd_decode
   import dram_cmd_pkg::*;
(
   input wire logic csN, // chip select, low active
   input wire logic rasN, // row strobe
   input wire logic casN, // column strobe
   input wire logic weN, // write enable
   output cmd_t cmd // decoded pin command
);
   function automatic cmd_t decode(input logic [3:0] p);
      cmd_t c;
      c = CMD_DES;
      unique case (p)
         4'h0: c = CMD_MRS;
         4'h1: c = CMD_REF;
         4'h2: c = CMD_PRE;
         4'h3: c = CMD_ACT;
         4'h4: c = CMD_WR;
         4'h5: c = CMD_RD;
         4'h6: c = CMD_ZQ;
         4'h7: c = CMD_NOP;
         default: c = CMD_DES;
      endcase
      return c;
   endfunction : decode

   assign cmd = decode({csN, rasN, casN, weN});
endmodule : dram_cmd_decode

// ### dram_device_end.sv
// dram end: samples the link, decodes commands and clock-enable moves, tracks banks
// assumes a link clock much slower than clk, all link pins from the controller
// Contract
// - commands registered only at link rising edge
// - controller holds reset pin high normally
// - termination pin never changes decoding
// - mode set writes register picked by bank
// - bank commands hit only addressed bank; precharge with A10 set closes every bank
// - controller drives valid pins to levels
// - self refresh exit needs no clock
// - bursts always run to completion
// - A10 auto precharge, A12 chop when enabled
// - no-operation leaves running work alone
// - deselect acts as no-operation
// - power-down performs no refresh
// - first long calibration is initial one
// - controller issues only listed combinations
// - enable held minimum edges after change
// - action from state, previous and present enable
// - power-down entry, stay and exit
// - self refresh only from idle, refresh encoding
// - controller idles with no-operation
// - address fields sized by configuration
`include "dram_link_map.svh"
module dram_device_end
   import dram_cmd_pkg::*;
#(
   parameter int ROW_W = `DRAM_ROW_W,
   parameter int COL_W = `DRAM_COL_W
)
(
   input wire logic clk, // 20 mhz system clock
   input wire logic rst_b, // synchronous reset, low active
   dram_link_if.dev link, // command link from controller
   output dev_state_t state, // power and bank state
   output logic cmdStrobe, // one cycle per executed command
   output cmd_t lastCmd, // last executed command
   output logic [`DRAM_BANK_W-1:0] cmdBank, // bank of last command
   output logic [ROW_W-1:0] rowAddr, // row of last activate
   output logic [COL_W-1:0] colAddr, // column of last read or write
   output logic autoPre, // last read or write auto-precharges
   output logic burstChop, // last burst is a 4-beat chop
   output logic bursting, // burst in progress
   output logic [`DRAM_BANKS-1:0] openBanks, // one bit per open bank
   output logic refreshPulse, // one cycle per refresh command
   output logic zqPulse, // one cycle per calibration command
   output logic zqLong, // last calibration was long
   output logic zqInit, // last calibration was long and the initial one
   output logic [`DRAM_ADDR_W-1:0] mr0 // mode register 0
);
   localparam int PIN_W = 7 + `DRAM_BANK_W + `DRAM_ADDR_W;
   localparam logic [2:0] B8 = 3'(`BURST8_CK);
   localparam logic [2:0] B4 = 3'(`BURST4_CK);

   function automatic logic [COL_W-1:0] colField(input logic [`DRAM_ADDR_W-1:0] adr);
      logic [11:0] full;
      full = {1'b0, adr[11], adr[9:0]};
      return full[COL_W-1:0];
   endfunction : colField

   logic [PIN_W-1:0] pinMeta;
   logic [PIN_W-1:0] pinSync;
   logic ckPrev;
   logic ckePrev;
   logic zqSeen;
   logic [2:0] burstCnt;
   logic [`DRAM_BANK_W-1:0] burstBank;
   logic [`DRAM_ADDR_W-1:0] modeRegs [`DRAM_MR_COUNT];
   dev_state_t next_state;
   logic [`DRAM_BANKS-1:0] next_openBanks;
   cmd_t pinCmd;

   // odt is deliberately not sampled: decoding is the same at any level
   wire [PIN_W-1:0] rawPins = {link.ck, link.cke, link.csN, link.rasN, link.casN, link.weN, link.resetN,
      link.ba, link.a};
   wire ckS = pinSync[PIN_W-1];
   wire ckeS = pinSync[PIN_W-2];
   wire csS = pinSync[PIN_W-3];
   wire rasS = pinSync[PIN_W-4];
   wire casS = pinSync[PIN_W-5];
   wire weS = pinSync[PIN_W-6];
   wire resetNS = pinSync[PIN_W-7];
   wire [`DRAM_BANK_W-1:0] baS = pinSync[`DRAM_ADDR_W +: `DRAM_BANK_W];
   wire [`DRAM_ADDR_W-1:0] aS = pinSync[`DRAM_ADDR_W-1:0];

   wire devReset = !rst_b || !resetNS;
   wire linkRise = ckS && !ckPrev;
   wire nopLike = (pinCmd == CMD_NOP) || (pinCmd == CMD_DES);
   wire normal = (state == S_IDLE) || (state == S_ACTIVE);
   wire ckeFall = linkRise && ckePrev && !ckeS;
   wire ckeRise = linkRise && !ckePrev && ckeS;
   wire busHeld = linkRise && ckePrev && ckeS;
   wire burstCmd = (pinCmd == CMD_RD) || (pinCmd == CMD_WR);
   wire execCmd = busHeld && normal && !nopLike && !(burstCmd && bursting);
   wire [1:0] blMode = modeRegs[0][`MR0_BL_POS +: 2];
   wire chopNow = (blMode == `MR0_BL_OTF) ? !aS[`DRAM_A12] : (blMode == `MR0_BL_FIX4);
   wire burstEnd = linkRise && (burstCnt == 3'h1);
   wire srExit = (state == S_SELFREF) && ckeS && nopLike;

   dram_cmd_decode u_decode (
      .csN(csS),
      .rasN(rasS),
      .casN(casS),
      .weN(weS),
      .cmd(pinCmd)
   );

   always_comb begin
      next_openBanks = openBanks;
      if (burstEnd && autoPre) begin
         next_openBanks[burstBank] = 1'b0;
      end
      if (execCmd && pinCmd == CMD_ACT) begin
         next_openBanks[baS] = 1'b1;
      end
      if (execCmd && pinCmd == CMD_PRE) begin
         if (aS[`DRAM_A10]) begin
            next_openBanks = '0;
         end else begin
            next_openBanks[baS] = 1'b0;
         end
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE, S_ACTIVE: begin
            if (ckeFall && pinCmd == CMD_REF && state == S_IDLE && !bursting) begin
               next_state = S_SELFREF;
            end else if (ckeFall && nopLike) begin
               next_state = (openBanks != '0) ? S_PD_ACT : S_PD_PRE;
            end else begin
               next_state = (next_openBanks != '0) ? S_ACTIVE : S_IDLE;
            end
         end
         S_PD_ACT, S_PD_PRE: begin
            // no refresh runs while here
            if (ckeRise && nopLike) begin
               next_state = (openBanks != '0) ? S_ACTIVE : S_IDLE;
            end
         end
         S_SELFREF: begin
            if (srExit) begin
               next_state = S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pinMeta <= '0;
         pinSync <= '0;
         ckPrev <= 1'b0;
      end else begin
         pinMeta <= rawPins;
         pinSync <= pinMeta;
         ckPrev <= ckS;
      end
   end

   always_ff @(posedge clk) begin
      if (devReset) begin
         state <= S_IDLE;
         ckePrev <= 1'b0;
         openBanks <= '0;
      end else begin
         state <= next_state;
         openBanks <= next_openBanks;
         if (linkRise) begin
            ckePrev <= ckeS;
         end else if (srExit) begin
            ckePrev <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (devReset) begin
         cmdStrobe <= 1'b0;
         refreshPulse <= 1'b0;
         zqPulse <= 1'b0;
         lastCmd <= CMD_NOP;
         cmdBank <= '0;
      end else begin
         cmdStrobe <= execCmd;
         refreshPulse <= execCmd && (pinCmd == CMD_REF);
         zqPulse <= execCmd && (pinCmd == CMD_ZQ);
         if (execCmd) begin
            lastCmd <= pinCmd;
            cmdBank <= baS;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (devReset) begin
         for (int i = 0; i < `DRAM_MR_COUNT; i++) begin
            modeRegs[i] <= '0;
         end
      end else if (execCmd && pinCmd == CMD_MRS) begin
         modeRegs[baS[1:0]] <= aS;
      end
   end

   always_ff @(posedge clk) begin
      if (devReset) begin
         rowAddr <= '0;
         colAddr <= '0;
         autoPre <= 1'b0;
         burstChop <= 1'b0;
         burstBank <= '0;
      end else if (execCmd && pinCmd == CMD_ACT) begin
         rowAddr <= aS[ROW_W-1:0];
      end else if (execCmd && burstCmd) begin
         colAddr <= colField(aS);
         autoPre <= aS[`DRAM_A10];
         burstChop <= chopNow;
         burstBank <= baS;
      end
   end

   // counts link cycles; only reset, never a command, stops it
   always_ff @(posedge clk) begin
      if (devReset) begin
         burstCnt <= '0;
      end else if (execCmd && burstCmd) begin
         burstCnt <= chopNow ? B4 : B8;
      end else if (linkRise && burstCnt != '0) begin
         burstCnt <= burstCnt - 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (devReset) begin
         zqSeen <= 1'b0;
         zqLong <= 1'b0;
         zqInit <= 1'b0;
      end else if (execCmd && pinCmd == CMD_ZQ) begin
         zqLong <= aS[`DRAM_A10];
         zqInit <= aS[`DRAM_A10] && !zqSeen;
         zqSeen <= zqSeen || aS[`DRAM_A10];
      end
   end

   assign bursting = burstCnt != '0;
   assign mr0 = modeRegs[0];
endmodule : dram_device_end

// ### dram_ctrl_end.sv
// controller end: avalon-mm command registers, link clock divider, pin sequencing
// assumes software writes one order at a time and waits on waitrequest
`include "dram_link_map.svh"
module dram_ctrl_end
   import dram_cmd_pkg::*;
#(
   parameter int DIV = `LINK_DIV,
   parameter int TCKE_MIN = `TCKE_MIN_CK,
   parameter int TRFC = `TRFC_CK,
   parameter int TZQINIT = `TZQINIT_CK,
   parameter int TZQOPER = `TZQOPER_CK,
   parameter int TZQCS = `TZQCS_CK
)
(
   input wire logic clk, // 20 mhz system clock
   input wire logic rst_b, // synchronous reset, low active
   input wire logic [3:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   dram_link_if.ctrl link // command link to dram
);
   localparam int DW = $clog2(DIV);

   function automatic logic [3:0] encode(input cmd_t c);
      unique case (c)
         CMD_DES: return 4'hf;
         CMD_MRS: return 4'h0;
         CMD_REF, CMD_SRE: return 4'h1;
         CMD_PRE: return 4'h2;
         CMD_ACT: return 4'h3;
         CMD_WR: return 4'h4;
         CMD_RD: return 4'h5;
         CMD_ZQ: return 4'h6;
         default: return 4'h7;
      endcase
   endfunction : encode

   logic [DW-1:0] divCnt;
   logic [1:0] ctrlReg;
   ctl_state_t cState;
   cmd_t pendCmd;
   logic [`DRAM_BANK_W-1:0] pendBank;
   logic [`DRAM_ADDR_W-1:0] pendAddr;
   logic [9:0] waitCnt;
   logic [9:0] next_wait;
   logic inSelfRef;
   logic zqDone;
   logic rejected;
   logic rdDone;

   wire linkFall = divCnt == DW'(DIV - 1);
   wire [DW-1:0] next_div = linkFall ? '0 : divCnt + 1'b1;
   wire selCtrl = avs_address == `REG_CTRL;
   wire selCmd = avs_address == `REG_CMD;
   wire selStat = avs_address == `REG_STATUS;
   wire busy = cState != C_READY;
   wire cmd_t wrCmd = cmd_t'(avs_writedata[`CMD_CODE_POS +: 4]);
   wire ckeOn = link.cke;
   wire legal = ckeOn ? !(wrCmd inside {CMD_PDX, CMD_SRX}) :
      ((wrCmd == CMD_PDX) && !inSelfRef) || ((wrCmd == CMD_SRX) && inSelfRef);
   wire cmdWrite = avs_write && selCmd && !busy;
   wire ckeMove = pendCmd inside {CMD_PDE, CMD_PDX, CMD_SRE, CMD_SRX};
   wire [31:0] statusWord = {27'h0, zqDone, inSelfRef, rejected, ckeOn, busy};

   assign avs_waitrequest = (avs_write && selCmd && busy) || (avs_read && !rdDone);

   // guard time after each order, in link cycles
   always_comb begin
      next_wait = 10'h0;
      unique case (pendCmd)
         CMD_RD, CMD_WR: next_wait = 10'(`BURST8_CK);
         CMD_REF: next_wait = 10'(TRFC);
         CMD_ZQ: next_wait = !pendAddr[`DRAM_A10] ? 10'(TZQCS) : (zqDone ? 10'(TZQOPER) : 10'(TZQINIT));
         default: next_wait = ckeMove ? 10'(TCKE_MIN) : 10'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         divCnt <= '0;
         link.ck <= 1'b0;
      end else begin
         divCnt <= next_div;
         link.ck <= next_div >= DW'(DIV / 2);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrlReg <= `CTRL_RESET;
         rdDone <= 1'b0;
         avs_readdata <= '0;
      end else begin
         if (avs_write && selCtrl) begin
            ctrlReg <= avs_writedata[1:0];
         end
         rdDone <= avs_read && !rdDone;
         if (avs_read && !rdDone) begin
            avs_readdata <= selCtrl ? {30'h0, ctrlReg} : (selStat ? statusWord : 32'h0);
         end
      end
   end

   assign link.resetN = ctrlReg[`CTRL_RESETN_POS];
   assign link.odt = ctrlReg[`CTRL_ODT_POS];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cState <= C_READY;
         pendCmd <= CMD_NOP;
         pendBank <= '0;
         pendAddr <= '0;
         waitCnt <= '0;
         rejected <= 1'b0;
      end else begin
         unique case (cState)
            C_READY: if (cmdWrite) begin
               rejected <= !legal;
               pendCmd <= wrCmd;
               pendBank <= avs_writedata[`CMD_BANK_POS +: `DRAM_BANK_W];
               pendAddr <= avs_writedata[`CMD_ADDR_POS +: `DRAM_ADDR_W];
               cState <= legal ? C_DRIVE : C_READY;
            end
            C_DRIVE: if (linkFall) begin
               cState <= C_HOLD;
            end
            C_HOLD: if (linkFall) begin
               waitCnt <= next_wait;
               cState <= C_WAIT;
            end
            C_WAIT: if (waitCnt == '0) begin
               cState <= C_READY;
            end else if (linkFall) begin
               waitCnt <= waitCnt - 10'h1;
            end
         endcase
      end
   end

   // pins change at the link falling edge, so they are steady at the rising edge
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         link.cke <= 1'b0;
         {link.csN, link.rasN, link.casN, link.weN} <= 4'h7;
         link.ba <= '0;
         link.a <= '0;
         inSelfRef <= 1'b0;
         zqDone <= 1'b0;
      end else if (linkFall && cState == C_DRIVE) begin
         {link.csN, link.rasN, link.casN, link.weN} <= encode(pendCmd);
         link.ba <= pendBank;
         link.a <= pendAddr;
         if (pendCmd inside {CMD_PDE, CMD_SRE}) begin
            link.cke <= 1'b0;
         end else if (pendCmd inside {CMD_PDX, CMD_SRX}) begin
            link.cke <= 1'b1;
         end
         inSelfRef <= (pendCmd == CMD_SRE) || (inSelfRef && pendCmd != CMD_SRX);
      end else if (linkFall && cState == C_HOLD) begin
         // set with the guard load, so the first long calibration still gets the initial span
         zqDone <= zqDone || (pendCmd == CMD_ZQ && pendAddr[`DRAM_A10]);
         {link.csN, link.rasN, link.casN, link.weN} <= 4'h7;
         link.ba <= '0;
         link.a <= '0;
      end
   end
endmodule : dram_ctrl_end

// ### dram_link_sva.sv
// concurrent checks on the dram command link between the two ends
// assumes clk samples the link and rst_b is the synchronous low reset of that domain
module dram_link_sva #(
   parameter int TCKE_MIN = 3
) (
   input wire logic clk, // system clock
   input wire logic rst_b, // synchronous reset, low active
   input wire logic ck, // link clock
   input wire logic cke, // clock enable
   input wire logic csN, // chip select, low active
   input wire logic rasN, // row strobe
   input wire logic casN, // column strobe
   input wire logic weN, // write enable
   input wire logic resetN, // dram reset, low active
   input wire logic [2:0] ba, // bank address
   input wire logic [15:0] a // address
);
   logic ckQ;
   logic ckeLast;
   logic [3:0] ckeAge;
   logic [3:0] burstAge;
   wire ckRise = ck && !ckQ;
   wire isIdle = csN || ({rasN, casN, weN} == 3'b111);
   wire isRef = !csN && ({rasN, casN, weN} == 3'b001);
   wire isBurst = !csN && ({rasN, casN} == 2'b10);
   wire isCmd = ckRise && cke && ckeLast && !isIdle;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge clk) begin
      ckQ <= rst_b && ck;
      ckeLast <= !rst_b ? 1'b0 : (ckRise ? cke : ckeLast);
   end
   // link rising edges since the last cke move and since the last burst
   always_ff @(posedge clk) begin
      if (!rst_b || $changed(cke)) ckeAge <= rst_b ? 4'h0 : 4'hf;
      else if (ckRise && ckeAge != 4'hf) ckeAge <= ckeAge + 4'h1;
   end
   always_ff @(posedge clk) begin
      if (!rst_b || (ckRise && cke && isBurst)) burstAge <= rst_b ? 4'h0 : 4'hf;
      else if (ckRise && burstAge != 4'hf) burstAge <= burstAge + 4'h1;
   end
   AST_CK_HIGH_HALF: assert property ($rose(ck) |=> ck[*3] ##1 !ck)
      else $error("link clock high phase not four clocks");
   AST_PINS_AT_FALL: assert property ($changed({cke, csN, rasN, casN, weN, ba, a}) |-> $fell(ck))
      else $error("link pins moved away from a falling link edge");
   AST_CKE_HOLD: assert property ($changed(cke) |-> ckeAge >= TCKE_MIN)
      else $error("clock enable moved too soon");
   AST_CKE_FALL_CMD: assert property (ckRise && !cke && ckeLast |-> isIdle || isRef)
      else $error("clock enable fell with a wrong command");
   AST_CKE_RISE_CMD: assert property (ckRise && cke && !ckeLast |-> isIdle)
      else $error("clock enable rose without idle pins");
   AST_LOW_CKE_QUIET: assert property (ckRise && !cke && !ckeLast |-> isIdle)
      else $error("command while clock enable low");
   AST_RESET_QUIET: assert property (!resetN |-> !cke && !csN && isIdle)
      else $error("link active while dram held in reset");
   AST_BURST_WHOLE: assert property (isCmd |-> burstAge >= 4'h3)
      else $error("command cut into a running burst");
   cover property (ckRise && !cke && ckeLast && isRef);
   cover property (ckRise && !cke && ckeLast && isIdle);
   cover property (ckRise && cke && !ckeLast);
   cover property (ckRise && cke && ckeLast && isBurst);
endmodule : dram_link_sva

// ### dram_command_cke_decoder_test.sv
// self-checking bench: controller end and dram end joined by the link interface
// assumes the design files and the link map header are compiled first
`include "dram_link_map.svh"
module dram_command_cke_decoder_test
   import dram_cmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] avAddr = 4'h0;
   logic avRead = 1'b0;
   logic avWrite = 1'b0;
   logic [31:0] avWdata = 32'h0;
   logic [31:0] avRdata;
   logic avWait;
   logic [31:0] st;
   dev_state_t state;
   cmd_t lastCmd;
   logic [2:0] cmdBank;
   logic [15:0] rowAddr;
   logic [9:0] colAddr;
   logic autoPre, burstChop, bursting, refreshPulse, zqLong, zqInit, cmdStrobe, zqPulse;
   logic [7:0] openBanks;
   logic [15:0] mr0;
   int errTotal = 0;
   int checks = 0;
   int refCount = 0;
   int strobeCount = 0;
   int zqCount = 0;
   dram_link_if link();
   dram_ctrl_end #(.TCKE_MIN(`TCKE_MIN_CK), .TRFC(2), .TZQINIT(16), .TZQOPER(8), .TZQCS(4)) u_dram_ctrl_end (
      .clk(clk), .rst_b(rst_b), .avs_address(avAddr), .avs_read(avRead), .avs_write(avWrite),
      .avs_writedata(avWdata), .avs_readdata(avRdata), .avs_waitrequest(avWait), .link(link.ctrl));
   dram_device_end u_dram_device_end (.clk(clk), .rst_b(rst_b), .link(link.dev), .state(state), .cmdStrobe(cmdStrobe),
      .lastCmd(lastCmd), .cmdBank(cmdBank), .rowAddr(rowAddr), .colAddr(colAddr), .autoPre(autoPre),
      .burstChop(burstChop), .bursting(bursting), .openBanks(openBanks), .refreshPulse(refreshPulse),
      .zqPulse(zqPulse), .zqLong(zqLong), .zqInit(zqInit), .mr0(mr0));
   dram_link_sva #(.TCKE_MIN(`TCKE_MIN_CK)) u_dram_link_sva (.clk(clk), .rst_b(rst_b), .ck(link.ck),
      .cke(link.cke), .csN(link.csN), .rasN(link.rasN), .casN(link.casN), .weN(link.weN),
      .resetN(link.resetN), .ba(link.ba), .a(link.a));
   always #25 clk = ~clk;
   always @(posedge clk) if (refreshPulse === 1'b1) refCount++;
   always @(posedge clk) if (cmdStrobe === 1'b1) strobeCount++;
   always @(posedge clk) if (zqPulse === 1'b1) zqCount++;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errTotal++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one avalon transfer; read data lands in st
   task automatic av(input logic wr, input logic [3:0] ad, input logic [31:0] d);
      @(posedge clk);
      avAddr <= ad;
      avWdata <= d;
      avWrite <= wr;
      avRead <= !wr;
      do begin
         @(posedge clk);
      end while (avWait !== 1'b0);
      st = avRdata;
      avWrite <= 1'b0;
      avRead <= 1'b0;
   endtask : av
   task automatic order(input cmd_t c, input logic [2:0] bk, input logic [15:0] ad);
      int n = 0;
      av(1'b1, `REG_CMD, {ad, 9'h000, bk, c});
      st = 32'h1;
      while (st[0] !== 1'b0 && n < 400) begin
         av(1'b0, `REG_STATUS, 32'h0);
         n++;
      end
      if (n >= 400) errTotal++;
      // link edge plus synchroniser latency on the dram side
      repeat (16) @(posedge clk);
   endtask : order
   task automatic dev(input dev_state_t s, input logic [7:0] ob);
      check("state", {29'h0, state}, {29'h0, s});
      check("openBanks", {24'h0, openBanks}, {24'h0, ob});
   endtask : dev
   task automatic t_bringup;
      av(1'b0, `REG_CTRL, 32'h0);
      check("ctrl", st, 32'h0);
      av(1'b1, 4'hc, 32'hffff_ffff);
      av(1'b0, 4'hc, 32'h0);
      check("unmapped", st, 32'h0);
      av(1'b1, `REG_CTRL, 32'h1);
      repeat (4) @(posedge clk);
      order(CMD_PDX, 3'h0, 16'h0);
      av(1'b0, `REG_STATUS, 32'h0);
      check("status cke", st & 32'h6, 32'h2);
      dev(S_IDLE, 8'h00);
   endtask : t_bringup
   task automatic t_modes;
      for (int b = 0; b < 4; b++) order(CMD_MRS, 3'(b), 16'(b * 4 + 1));
      check("mr0", {16'h0, mr0}, 32'h1);
      check("mr bank", {29'h0, cmdBank}, 32'h3);
   endtask : t_modes
   task automatic t_banks;
      int n = 0;
      order(CMD_ACT, 3'h2, 16'h0012);
      dev(S_ACTIVE, 8'h04);
      check("row", {16'h0, rowAddr}, 32'h12);
      order(CMD_ACT, 3'h5, 16'h0034);
      dev(S_ACTIVE, 8'h24);
      order(CMD_RD, 3'h2, 16'h0005);
      check("read", {autoPre, burstChop, 2'h0, lastCmd, 5'h0, cmdBank, 6'h0, colAddr}, 32'h4702_0005);
      order(CMD_WR, 3'h5, 16'h1407);
      while (bursting !== 1'b0 && n < 200) begin
         @(posedge clk);
         n++;
      end
      check("write", {autoPre, burstChop, 2'h0, lastCmd, 5'h0, cmdBank, 6'h0, colAddr}, 32'h8605_0007);
      dev(S_ACTIVE, 8'h04);
      order(CMD_ACT, 3'h3, 16'h0001);
      order(CMD_PRE, 3'h2, 16'h0000);
      dev(S_ACTIVE, 8'h08);
      order(CMD_PRE, 3'h1, 16'h0400);
      dev(S_IDLE, 8'h00);
      order(CMD_MRS, 3'h0, 16'(`MR0_BL_FIX4));
      order(CMD_ACT, 3'h0, 16'h0002);
      order(CMD_RD, 3'h0, 16'h1000);
      check("fixed chop", {31'h0, burstChop}, 32'h1);
      order(CMD_PRE, 3'h0, 16'h0400);
   endtask : t_banks
   task automatic t_zq;
      int z = zqCount;
      av(1'b1, `REG_CTRL, 32'h3);
      order(CMD_ZQ, 3'h0, 16'h0400);
      check("zq first", {zqLong, zqInit}, 2'h3);
      order(CMD_ZQ, 3'h0, 16'h0400);
      check("zq later", {zqLong, zqInit}, 2'h2);
      order(CMD_ZQ, 3'h0, 16'h0000);
      check("zq short", {27'h0, zqLong, lastCmd}, {28'h0, CMD_ZQ});
      check("zq pulses", zqCount, z + 3);
      av(1'b1, `REG_CTRL, 32'h1);
   endtask : t_zq
   task automatic t_power;
      int r = refCount;
      int s = 0;
      order(CMD_REF, 3'h0, 16'h0);
      check("refreshes", refCount, r + 1);
      order(CMD_PDE, 3'h0, 16'h0);
      dev(S_PD_PRE, 8'h00);
      repeat (200) @(posedge clk);
      check("refreshes in power-down", refCount, r + 1);
      order(CMD_PDX, 3'h0, 16'h0);
      dev(S_IDLE, 8'h00);
      order(CMD_ACT, 3'h1, 16'h0009);
      order(CMD_PDE, 3'h0, 16'h0);
      dev(S_PD_ACT, 8'h02);
      order(CMD_PDX, 3'h0, 16'h0);
      s = strobeCount;
      order(CMD_DES, 3'h4, 16'h0400);
      order(CMD_NOP, 3'h4, 16'h0400);
      dev(S_ACTIVE, 8'h02);
      check("strobes on idle pins", strobeCount, s);
      order(CMD_PRE, 3'h0, 16'h0400);
   endtask : t_power
   task automatic t_selfref;
      order(CMD_SRE, 3'h0, 16'h0);
      dev(S_SELFREF, 8'h00);
      order(CMD_PDX, 3'h0, 16'h0);
      av(1'b0, `REG_STATUS, 32'h0);
      check("status in self refresh", st & 32'he, 32'hc);
      order(CMD_SRX, 3'h0, 16'h0);
      dev(S_IDLE, 8'h00);
      order(CMD_SRX, 3'h0, 16'h0);
      av(1'b0, `REG_STATUS, 32'h0);
      check("exit refused", st & 32'he, 32'h6);
   endtask : t_selfref
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, errTotal);
      if (errTotal == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      t_bringup;
      t_modes;
      t_banks;
      t_zq;
      t_power;
      t_selfref;
      wrap_up;
   end
   initial begin
      repeat (40000) @(posedge clk);
      errTotal++;
      wrap_up;
   end
endmodule : dram_command_cke_decoder_test
